// File: rtl/dpr_defs.vh
`ifndef DPR_DEFS_VH
`define DPR_DEFS_VH

// geometry
`define DPR_AW          5
`define DPR_DW          4
`define DPR_WORDS       32

// register offsets (byte addresses)
`define DPR_OFF_CTRL    12'h000
`define DPR_OFF_CLEAR   12'h004
`define DPR_OFF_STATUS  12'h008
`define DPR_OFF_WCOUNT  12'h00C
`define DPR_OFF_LAST    12'h010
`define DPR_OFF_WIN     12'h080
`define DPR_WIN_MASK    12'hF80

// control fields
`define DPR_CTRL_SYNC   0
`define DPR_CTRL_SINGLE 1
`define DPR_CTRL_RIGHT  2
`define DPR_CTRL_CFG    3
`define DPR_CTRL_RST    4'h0

// status fields
`define DPR_ST_CLKLVL   0
`define DPR_ST_SINGLE   1
`define DPR_ST_CLRDONE  2
`define DPR_ST_FEWEN    3
`define DPR_ST_FEADDR   8
`define DPR_ST_FEDATA   16

// reset values
`define DPR_WCOUNT_RST  16'h0000
`define DPR_LAST_RST    9'h000

`endif

// File: rtl/dpr_sync3.v
`timescale 1ns/1ps
// three-stage pin synchroniser, change taken when stages two and three agree
module dpr_sync3 (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output reg  level_o,
  output wire rise_o
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

  assign rise_o = (s2 == s3) & s3 & ~level_o;

endmodule

// File: rtl/dpr_store.v
`timescale 1ns/1ps
`include "dpr_defs.vh"
// 32 x 4 storage nibbles with asynchronous read and whole-array clear
module dpr_store (
  input  wire                  clk_i,
  input  wire                  clr_i,
  input  wire                  we_i,
  input  wire [`DPR_AW-1:0]    waddr_i,
  input  wire [`DPR_DW-1:0]    wdata_i,
  input  wire [`DPR_AW-1:0]    raddr_i,
  output wire [`DPR_DW-1:0]    rdata_o,
  input  wire [`DPR_AW-1:0]    peek_addr_i,
  output wire [`DPR_DW-1:0]    peek_data_o
);

  reg [`DPR_DW-1:0] mem [0:`DPR_WORDS-1];
  integer i;

  // clear wins over a write in the same cycle
  always @(posedge clk_i) begin
    if (clr_i) begin
      for (i = 0; i < `DPR_WORDS; i = i + 1) begin
        mem[i] <= {`DPR_DW{1'b0}};
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o     = mem[raddr_i];
  assign peek_data_o = mem[peek_addr_i];

endmodule

// File: rtl/dpr_ram_block.v
`timescale 1ns/1ps
`include "dpr_defs.vh"
module dpr_ram_block (
  input  wire                 clk_i,
  input  wire                 rst_i,
  // apb slave
  input  wire                 psel_i,
  input  wire                 penable_i,
  input  wire                 pwrite_i,
  input  wire [11:0]          paddr_i,
  input  wire [31:0]          pwdata_i,
  output reg  [31:0]          prdata_o,
  output wire                 pready_o,
  output wire                 pslverr_o,
  // user fabric side
  input  wire                 sector_clk_i,
  input  wire [`DPR_AW-1:0]   waddr_i,
  input  wire [`DPR_AW-1:0]   raddr_i,
  input  wire                 wen_n_i,
  input  wire [`DPR_DW-1:0]   din_i,
  input  wire                 output_enable_n_i,
  output wire [`DPR_DW-1:0]   dout_o,
  output wire                 dout_oe_o,
  output wire [`DPR_DW-1:0]   dport_o,
  output wire                 dport_oe_o
);

  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr[11:2] == off[11:2]);
    end
  endfunction

  // control register
  localparam [3:0]    CTRL_RST = `DPR_CTRL_RST;
  reg                 sync_mode;
  reg                 single_cfg;
  reg                 right_most;
  reg                 cfg_active;

  // front-end latches
  reg [`DPR_AW-1:0]   fe_addr;
  reg                 fe_wen_n;
  reg [`DPR_DW-1:0]   fe_data;

  // observation state
  reg [15:0]          wcount;
  reg [8:0]           last_wr;
  reg                 clr_done;

  wire                clk_lvl;
  wire                clk_rise;
  wire                load;
  wire                single_eff;
  wire [`DPR_AW-1:0]  eff_addr;
  wire                eff_wen_n;
  wire [`DPR_DW-1:0]  eff_data;
  wire                store_we;
  wire [`DPR_AW-1:0]  rd_addr;
  wire [`DPR_DW-1:0]  rd_data;
  wire [`DPR_DW-1:0]  rd_view;
  wire                flow;
  wire [`DPR_DW-1:0]  peek_data;

  wire                acc;
  wire                wr_acc;
  wire                rd_acc;
  wire                sel_ctrl;
  wire                sel_clear;
  wire                sel_status;
  wire                sel_wcount;
  wire                sel_last;
  wire                sel_win;
  wire                mapped;
  wire                clr_req;
  reg  [31:0]         next_rdata;

  dpr_sync3 u_clk_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (sector_clk_i),
    .level_o (clk_lvl),
    .rise_o  (clk_rise)
  );

  assign load = sync_mode ? clk_rise : 1'b1;

  assign single_eff = single_cfg | right_most;

  assign eff_addr  = load ? waddr_i : fe_addr;
  assign eff_wen_n = load ? wen_n_i : fe_wen_n;
  assign eff_data  = load ? din_i   : fe_data;

  // capture on the selected clock edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      fe_addr  <= {`DPR_AW{1'b0}};
      fe_wen_n <= 1'b1;
      fe_data  <= {`DPR_DW{1'b0}};
    end else if (load) begin
      fe_addr  <= waddr_i;
      fe_wen_n <= wen_n_i;
      fe_data  <= din_i;
    end
  end

  // addressed nibble written while load 1 and enable low
  // write lands only on the load edge in sync mode
  assign store_we = load & ~eff_wen_n & ~clr_req;

  // single port reads through the write address
  assign rd_addr = single_eff ? waddr_i : raddr_i;

  // storage with separate write and read addresses
  dpr_store u_store (
    .clk_i       (clk_i),
    .clr_i       (clr_req),
    .we_i        (store_we),
    .waddr_i     (eff_addr),
    .wdata_i     (eff_data),
    .raddr_i     (rd_addr),
    .rdata_o     (rd_data),
    .peek_addr_i (paddr_i[6:2]),
    .peek_data_o (peek_data)
  );

  // flow-through of new data on matching addresses
  assign flow    = store_we & (eff_addr == rd_addr);
  assign rd_view = flow ? eff_data : rd_data;

  // separate read data bus in dual-port mode
  // driven only while output enable is low
  assign dout_o    = rd_view;
  assign dout_oe_o = ~output_enable_n_i & ~single_eff;

  // bidirectional data port in single-port mode
  assign dport_o    = rd_view;
  assign dport_oe_o = ~output_enable_n_i & single_eff & wen_n_i;

  // apb decode
  assign acc        = psel_i & penable_i;
  assign wr_acc     = acc & pwrite_i;
  assign rd_acc     = acc & ~pwrite_i;
  assign sel_ctrl   = hit(paddr_i, `DPR_OFF_CTRL);
  assign sel_clear  = hit(paddr_i, `DPR_OFF_CLEAR);
  assign sel_status = hit(paddr_i, `DPR_OFF_STATUS);
  assign sel_wcount = hit(paddr_i, `DPR_OFF_WCOUNT);
  assign sel_last   = hit(paddr_i, `DPR_OFF_LAST);
  assign sel_win    = (paddr_i & `DPR_WIN_MASK) == `DPR_OFF_WIN;
  assign mapped     = sel_ctrl | sel_clear | sel_status | sel_wcount |
                      sel_last | sel_win;

  assign pready_o  = 1'b1;
  assign pslverr_o = acc & (~mapped | (pwrite_i & sel_win));

  // clear byte honoured only during configuration
  assign clr_req = wr_acc & sel_clear & cfg_active;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_mode  <= CTRL_RST[`DPR_CTRL_SYNC];
      single_cfg <= CTRL_RST[`DPR_CTRL_SINGLE];
      right_most <= CTRL_RST[`DPR_CTRL_RIGHT];
      cfg_active <= CTRL_RST[`DPR_CTRL_CFG];
    end else if (wr_acc & sel_ctrl) begin
      sync_mode  <= pwdata_i[`DPR_CTRL_SYNC];
      single_cfg <= pwdata_i[`DPR_CTRL_SINGLE];
      right_most <= pwdata_i[`DPR_CTRL_RIGHT];
      cfg_active <= pwdata_i[`DPR_CTRL_CFG];
    end
  end

  // write counter, a software write clears it; with a fabric write in the same cycle it restarts at one
  always @(posedge clk_i) begin
    if (rst_i) begin
      wcount <= `DPR_WCOUNT_RST;
    end else if (store_we) begin
      if (wr_acc & sel_wcount) begin
        wcount <= 16'h0001;
      end else begin
        wcount <= wcount + 16'h0001;
      end
    end else if (wr_acc & sel_wcount) begin
      wcount <= `DPR_WCOUNT_RST;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      last_wr <= `DPR_LAST_RST;
    end else if (store_we) begin
      last_wr <= {eff_addr, eff_data};
    end
  end

  // sticky clear-done, cleared by a control write; a new clear wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      clr_done <= 1'b0;
    end else if (clr_req) begin
      clr_done <= 1'b1;
    end else if (wr_acc & sel_ctrl) begin
      clr_done <= 1'b0;
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (sel_ctrl) begin
      next_rdata[`DPR_CTRL_SYNC]   = sync_mode;
      next_rdata[`DPR_CTRL_SINGLE] = single_cfg;
      next_rdata[`DPR_CTRL_RIGHT]  = right_most;
      next_rdata[`DPR_CTRL_CFG]    = cfg_active;
    end else if (sel_status) begin
      next_rdata[`DPR_ST_CLKLVL]  = clk_lvl;
      next_rdata[`DPR_ST_SINGLE]  = single_eff;
      next_rdata[`DPR_ST_CLRDONE] = clr_done;
      next_rdata[`DPR_ST_FEWEN]   = fe_wen_n;
      next_rdata[`DPR_ST_FEADDR +: `DPR_AW] = fe_addr;
      next_rdata[`DPR_ST_FEDATA +: `DPR_DW] = fe_data;
    end else if (sel_wcount) begin
      next_rdata[15:0] = wcount;
    end else if (sel_last) begin
      next_rdata[8:0] = last_wr;
    end else if (sel_win) begin
      next_rdata[`DPR_DW-1:0] = peek_data;
    end
  end

  // read data registered during setup, stable through access
  always @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= next_rdata;
    end else if (rd_acc) begin
      prdata_o <= prdata_o;
    end
  end

endmodule

// File: test/dpr_ram_block_checker.sv
`timescale 1ns/1ps
module dpr_ram_block_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire        sector_clk_i,
  input wire [4:0]  waddr_i,
  input wire [4:0]  raddr_i,
  input wire        wen_n_i,
  input wire [3:0]  din_i,
  input wire        output_enable_n_i,
  input wire [3:0]  dout_o,
  input wire        dout_oe_o,
  input wire        dport_oe_o
);
  reg  [3:0] ctrl;
  reg  [2:0] lcnt;
  reg        live = 1'b0;
  wire       wr = psel_i & penable_i & pwrite_i;
  wire       sp = ctrl[1] | ctrl[2];
  // shadow of mode bits and sector clock idle time
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 4'h0;
      lcnt <= 3'h0;
    end else begin
      if (wr && paddr_i[11:2] == 10'h000)
        ctrl <= pwdata_i[3:0];
      if (wr && paddr_i[11:2] == 10'h001 && ctrl[3])
        live <= 1'b1;
      lcnt <= sector_clk_i ? 3'h0 : lcnt + {2'h0, lcnt != 3'h7};
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_oe_off;
    output_enable_n_i |-> !dout_oe_o && !dport_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe off");
  property p_oe_on;
    !output_enable_n_i |-> dout_oe_o == !sp;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe on");
  property p_dport;
    dport_oe_o |-> sp && wen_n_i;
  endproperty
  a_dport: assert property (p_dport) else $error("dport");
  property p_flow;
    !ctrl[0] && !sp && !wen_n_i && !psel_i && !$past(psel_i)
      |=> raddr_i != $past(waddr_i) || !wen_n_i || dout_o == $past(din_i);
  endproperty
  a_flow: assert property (p_flow) else $error("write lost");
  property p_thru;
    !ctrl[0] && !sp && !wen_n_i && raddr_i == waddr_i && !psel_i
      && !$past(psel_i) |-> dout_o == din_i;
  endproperty
  a_thru: assert property (p_thru) else $error("no flow");
  property p_keep;
    live && wen_n_i && !psel_i && !$past(psel_i) |=> $stable(dout_o)
      || raddr_i != $past(raddr_i) || waddr_i != $past(waddr_i);
  endproperty
  a_keep: assert property (p_keep) else $error("not kept");
  property p_sync;
    live && ctrl[0] && lcnt > 3'h3 && !psel_i && !$past(psel_i)
      |=> $stable(dout_o) || raddr_i != $past(raddr_i)
      || waddr_i != $past(waddr_i);
  endproperty
  a_sync: assert property (p_sync) else $error("sync write");
  property p_clr;
    wr && paddr_i[11:2] == 10'h001 && ctrl[3] && wen_n_i
      |-> ##2 dout_o == 4'h0 || !$past(wen_n_i);
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
endmodule

// File: test/dpr_fabric_model.sv
`timescale 1ns/1ps
module dpr_fabric_model (
  input  wire       clk_i,
  output reg  [4:0] waddr_o = 5'h00,
  output reg  [4:0] raddr_o = 5'h00,
  output reg        wen_n_o = 1'b1,
  output reg  [3:0] din_o   = 4'h0,
  output reg        oen_n_o = 1'b1,
  output reg        sclk_o  = 1'b0
);
  // inputs held over the capturing edge
  task wr(input [4:0] a, input [3:0] d, input s);
    begin
      @(posedge clk_i);
      waddr_o <= a;
      raddr_o <= a;
      din_o <= d;
      wen_n_o <= 1'b0;
      oen_n_o <= 1'b1;
      if (s) begin
        @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
      @(posedge clk_i);
      wen_n_o <= 1'b1;
      din_o <= ~d;
    end
  endtask
  // read address moved away in single port
  task rd(input [4:0] a, input sp);
    begin
      @(posedge clk_i);
      waddr_o <= a;
      raddr_o <= sp ? ~a : a;
      oen_n_o <= 1'b0;
    end
  endtask
endmodule

// File: test/dpr_ram_block_test.sv
`timescale 1ns/1ps
module dpr_ram_block_test;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         psel_i = 1'b0;
  reg         penable_i = 1'b0;
  reg         pwrite_i = 1'b0;
  reg  [11:0] paddr_i = 12'h000;
  reg  [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, dout_oe_o, dport_oe_o;
  wire [4:0]  waddr_i, raddr_i;
  wire [3:0]  din_i, dout_o, dport_o;
  wire        wen_n_i, output_enable_n_i, sector_clk_i;
  reg  [1:0]  look = 2'h0;
  reg  [31:0] seed = 32'hE7D3;
  reg  [3:0]  mem [0:31];
  reg  [31:0] q [$];
  integer     err_total = 0;
  integer     cmp_count = 0;
  integer     i, m;
  always #50 clk_i = ~clk_i;
  dpr_ram_block dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sector_clk_i,
    .waddr_i, .raddr_i, .wen_n_i, .din_i, .output_enable_n_i, .dout_o,
    .dout_oe_o, .dport_o, .dport_oe_o);
  dpr_fabric_model fab (.clk_i, .waddr_o(waddr_i), .raddr_o(raddr_i),
    .wen_n_o(wen_n_i), .din_o(din_i), .oen_n_o(output_enable_n_i),
    .sclk_o(sector_clk_i));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
        @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      q.push_back(e);
      apb(1'b0, a, 32'h0);
    end
  endtask
  task look_at(input [4:0] a, input sp);
    begin
      fab.rd(a, sp);
      q.push_back({28'h0, mem[a]});
      look <= sp ? 2'h2 : 2'h1;
      @(posedge clk_i);
      look <= 2'h0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
      check(prdata_o, q.pop_front());
    if (psel_i && penable_i && pready_o === 1'b1)
      check({31'h0, pslverr_o}, {31'h0, paddr_i == 12'h040});
    if (look == 2'h1)
      check({28'h0, dout_o}, q.pop_front());
    if (look == 2'h2)
      check({28'h0, dport_o}, q.pop_front());
  end
  initial begin
    #5000000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    for (i = 0; i < 32; i = i + 1)
      mem[i] = 4'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h004, 32'h5A);
    for (i = 0; i < 32; i = i + 1)
      rd({5'h01, i[4:0], 2'h0}, 32'h0);
    $display("test done: clear");
    // async, sync, single and right-most modes
    for (m = 0; m < 4; m = m + 1) begin
      apb(1'b1, 12'h000, m == 3 ? 32'h4 : m);
      for (i = 0; i < 4; i = i + 1) begin
        seed = xs(seed);
        fab.wr(seed[4:0], seed[8:5], m == 1);
        mem[seed[4:0]] = seed[8:5];
        look_at(seed[4:0], m > 1);
        rd({5'h01, seed[4:0], 2'h0}, {28'h0, seed[8:5]});
      end
      $display("test done: mode %0d", m);
    end
    apb(1'b1, 12'h040, 32'hF);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    look_at(seed[4:0], 1'b0);
    $display("test done: refused");
    give_verdict;
  end
endmodule
bind dpr_ram_block dpr_ram_block_checker chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .sector_clk_i, .waddr_i,
  .raddr_i, .wen_n_i, .din_i, .output_enable_n_i, .dout_o, .dout_oe_o,
  .dport_oe_o);
